// file: common/lvs_pkg.sv
// Package: constants and register map of the line voltage supervisor
// What this block does
// - Integrator off at reset; offset MSB enables
// - Zero-cross output follows filtered voltage sign
// - Each crossing sets flag; enabled drives interrupt
// - Status-clear read resets flag and interrupt
// - 12-bit timeout counter decrements every 128 clocks
// - Crossing reloads counter from programmed timeout
// - Timeout register resets to 0xfff
// - Counter zero without crossing drives dip low
// - Timeout flag always set; interrupt needs enable
// - Timeout register at 0x1d read and write
// - 16-bit period updated each cycle, MSB zero
// - Period filtered, within one LSB steady
// - Low supply: inactive, filtered with hysteresis
// - Dip output low while supply inactive
// - Cycle setting is one more than cycles
// - Dip event sets flag; enabled drives interrupt
// - Dip released when magnitude reaches level
// - Level compared to doubled magnitude high byte
package lvs_pkg;
    // ========================================
    // Register map
    localparam logic [5:0] LVS_ADDR_OFFSET1 = 6'h0d;
    localparam logic [5:0] LVS_ADDR_IRQ_EN = 6'h0a;
    localparam logic [5:0] LVS_ADDR_STATUS = 6'h0b;
    localparam logic [5:0] LVS_ADDR_STATUS_CLR = 6'h0c;
    localparam logic [5:0] LVS_ADDR_MODE = 6'h09;
    localparam logic [5:0] LVS_ADDR_TIMEOUT = 6'h1d;
    localparam logic [5:0] LVS_ADDR_DIP_CYC = 6'h1e;
    localparam logic [5:0] LVS_ADDR_DIP_LVL = 6'h1f;
    localparam logic [5:0] LVS_ADDR_PERIOD = 6'h27;
    // ========================================
    // Field positions
    localparam int LVS_BIT_INTEG = 7;
    localparam int LVS_BIT_DIP_DIS = 3;
    localparam int LVS_ST_DIP = 1;
    localparam int LVS_ST_TIMEOUT = 3;
    localparam int LVS_ST_ZX = 4;
    // ========================================
    // Reset values
    localparam logic [11:0] LVS_TIMEOUT_RST = 12'hfff;
    localparam logic [7:0] LVS_DIP_CYC_RST = 8'hff;
    localparam logic [7:0] LVS_DIP_LVL_RST = 8'h00;
    localparam logic [15:0] LVS_IRQ_EN_RST = 16'h0000;
    localparam logic [15:0] LVS_MODE_RST = 16'h0000;
    // ========================================
    // Timing
    localparam int LVS_CLK_HZ = 10_000_000;
    localparam logic [6:0] LVS_TICK_DIV = 7'h7f;
    localparam int LVS_PERIOD_DIV_CLKS = 32;
    localparam int LVS_SETTLE_MS = 1800;
    localparam int LVS_SETTLE_CYC = LVS_SETTLE_MS * (LVS_CLK_HZ / 1000);
    localparam logic [3:0] LVS_SUPPLY_FILT = 4'hf;
endpackage

// file: design/lvs_period_filter.sv
// Period filter: running average of raw period counts
`timescale 1ns/10ps
module lvs_period_filter (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Raw sample in
    input wire logic sample_valid,
    input wire logic [14:0] sample,
    // Filtered value out
    output logic [15:0] period_q
);
    import lvs_pkg::*;
    logic [18:0] acc_q;
    logic primed_q;
    logic [18:0] acc_d;

    // First-order IIR, gain 1/8: slow settle traded for a steady LSB
    always_comb begin
        acc_d = acc_q - {3'h0, acc_q[18:3]} + {4'h0, sample};
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            acc_q <= 19'h00000;
            primed_q <= 1'b0;
            period_q <= 16'h0000;
        end else if (sample_valid) begin
            primed_q <= 1'b1;
            if (!primed_q) begin
                acc_q <= {1'b0, sample, 3'h0};
                period_q <= {1'b0, sample};
            end else begin
                acc_q <= acc_d;
                period_q <= {1'b0, acc_d[17:3]};
            end
        end
    end
endmodule

// file: design/lvs_supervisor.sv
// Line voltage supervisor: zero cross, timeout, period, dip, supply
`timescale 1ns/10ps
module lvs_supervisor (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register port
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // Voltage channel samples
    input wire logic sample_valid,
    input wire logic [15:0] first_lowpass_filter,
    // Supply monitor pin
    input wire logic analog_supply_ok,
    // Outputs
    output logic zero_cross_out,
    output logic irq_n,
    output logic dip_n,
    output logic integrator_en,
    output logic active
);
    import lvs_pkg::*;

    // ========================================
    // Registers
    logic [15:0] irq_en_q;
    logic [15:0] mode_q;
    logic [15:0] status_q;
    logic [5:0] offset1_q;
    logic [11:0] zero_cross_timeout_q;
    logic [7:0] dip_cycle_count_q;
    logic [7:0] dip_threshold_q;
    logic [15:0] line_period;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            irq_en_q <= LVS_IRQ_EN_RST;
            mode_q <= LVS_MODE_RST;
            offset1_q <= 6'h00;
            integrator_en <= 1'b0;
            zero_cross_timeout_q <= LVS_TIMEOUT_RST;
            dip_cycle_count_q <= LVS_DIP_CYC_RST;
            dip_threshold_q <= LVS_DIP_LVL_RST;
        end else if (reg_wr) begin
            if (reg_addr == LVS_ADDR_IRQ_EN) begin
                irq_en_q <= reg_wdata;
            end else if (reg_addr == LVS_ADDR_MODE) begin
                mode_q <= reg_wdata;
            end else if (reg_addr == LVS_ADDR_OFFSET1) begin
                offset1_q <= reg_wdata[5:0];
                integrator_en <= reg_wdata[LVS_BIT_INTEG];
            end else if (reg_addr == LVS_ADDR_TIMEOUT) begin
                zero_cross_timeout_q <= reg_wdata[11:0];
            end else if (reg_addr == LVS_ADDR_DIP_CYC) begin
                dip_cycle_count_q <= reg_wdata[7:0];
            end else if (reg_addr == LVS_ADDR_DIP_LVL) begin
                dip_threshold_q <= reg_wdata[7:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_addr == LVS_ADDR_IRQ_EN) begin
                reg_rdata <= irq_en_q;
            end else if (reg_addr == LVS_ADDR_MODE) begin
                reg_rdata <= mode_q;
            end else if (reg_addr == LVS_ADDR_OFFSET1) begin
                reg_rdata <= {8'h00, integrator_en, 1'b0, offset1_q};
            end else if (reg_addr == LVS_ADDR_STATUS ||
                         reg_addr == LVS_ADDR_STATUS_CLR) begin
                reg_rdata <= status_q;
            end else if (reg_addr == LVS_ADDR_TIMEOUT) begin
                reg_rdata <= {4'h0, zero_cross_timeout_q};
            end else if (reg_addr == LVS_ADDR_DIP_CYC) begin
                reg_rdata <= {8'h00, dip_cycle_count_q};
            end else if (reg_addr == LVS_ADDR_DIP_LVL) begin
                reg_rdata <= {8'h00, dip_threshold_q};
            end else if (reg_addr == LVS_ADDR_PERIOD) begin
                reg_rdata <= line_period;
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end

    // ========================================
    // Supply monitor
    logic sup_s1_q;
    logic sup_s2_q;
    logic [3:0] sup_cnt_q;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            sup_s1_q <= 1'b0;
            sup_s2_q <= 1'b0;
        end else begin
            sup_s1_q <= analog_supply_ok;
            sup_s2_q <= sup_s1_q;
        end
    end

    // Counter hysteresis: state flips only after a full run of agreement
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sup_cnt_q <= 4'h0;
            active <= 1'b0;
        end else if (sup_s2_q == active) begin
            sup_cnt_q <= 4'h0;
        end else if (sup_cnt_q == LVS_SUPPLY_FILT) begin
            sup_cnt_q <= 4'h0;
            active <= sup_s2_q;
        end else begin
            sup_cnt_q <= sup_cnt_q + 4'h1;
        end
    end

    // ========================================
    // Zero crossing
    logic sign_q;
    logic zx_ev;
    logic zx_rise;

    assign zx_ev = sample_valid && active && (first_lowpass_filter[15] == sign_q);
    assign zx_rise = zx_ev && !sign_q;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            // Last sign taken as negative, so no false edge after reset
            sign_q <= 1'b0;
            zero_cross_out <= 1'b0;
        end else if (sample_valid && active) begin
            sign_q <= ~first_lowpass_filter[15];
            if (zx_ev) begin
                zero_cross_out <= ~sign_q;
            end
        end
    end

    // ========================================
    // Timeout counter
    logic [6:0] div_q;
    logic tick;
    logic [11:0] to_cnt_q;
    logic to_ev;

    assign tick = (div_q == LVS_TICK_DIV);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            div_q <= 7'h00;
        end else begin
            div_q <= div_q + 7'h01;
        end
    end

    assign to_ev = active && tick && !zx_ev && (to_cnt_q == 12'h001);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            to_cnt_q <= LVS_TIMEOUT_RST;
        end else if (zx_ev) begin
            to_cnt_q <= zero_cross_timeout_q;
        end else if (active && tick && to_cnt_q != 12'h000) begin
            to_cnt_q <= to_cnt_q - 12'h001;
        end
    end

    // ========================================
    // Period measurement
    logic [14:0] per_cnt_q;
    logic per_seen_q;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            per_cnt_q <= 15'h0000;
            per_seen_q <= 1'b0;
        end else if (zx_rise) begin
            per_cnt_q <= 15'h0001;
            per_seen_q <= 1'b1;
        end else if (per_cnt_q != 15'h7fff) begin
            per_cnt_q <= per_cnt_q + 15'h0001;
        end
    end

    lvs_period_filter u_filt (
        .clock(clock),
        .rstn(rstn),
        .sample_valid(zx_rise && per_seen_q),
        .sample(per_cnt_q),
        .period_q(line_period)
    );

    // ========================================
    // Dip detection
    logic [15:0] mag;
    logic [7:0] mag_byte;
    logic below;
    logic [7:0] dip_cyc_q;
    logic dip_q;
    logic dip_ev;

    assign mag = first_lowpass_filter[15] ? (~first_lowpass_filter + 16'h0001)
                                          : first_lowpass_filter;
    assign mag_byte = mag[14:7];
    assign below = dip_threshold_q > mag_byte;

    logic below_cyc_q;

    // Cycles counted on rising crossings; setting minus one is the goal
    assign dip_ev = zx_rise && !dip_q && below_cyc_q &&
                    ({1'b0, dip_cyc_q} + 9'h002 >=
                     {1'b0, dip_cycle_count_q});

    always_ff @(posedge clock) begin
        if (!rstn) begin
            below_cyc_q <= 1'b1;
            dip_cyc_q <= 8'h00;
        end else if (sample_valid && active && !below) begin
            below_cyc_q <= 1'b0;
            dip_cyc_q <= 8'h00;
        end else if (zx_rise) begin
            if (below_cyc_q && dip_cyc_q != 8'hff) begin
                dip_cyc_q <= dip_cyc_q + 8'h01;
            end else if (!below_cyc_q) begin
                dip_cyc_q <= 8'h00;
            end
            below_cyc_q <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            dip_q <= 1'b0;
        end else if (dip_ev) begin
            dip_q <= 1'b1;
        end else if (sample_valid && active && !below) begin
            dip_q <= 1'b0;
        end
    end

    logic to_hit_q;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            to_hit_q <= 1'b0;
        end else if (zx_ev) begin
            to_hit_q <= 1'b0;
        end else if (to_ev) begin
            to_hit_q <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            dip_n <= 1'b0;
        end else if (!active) begin
            dip_n <= 1'b0;
        end else begin
            dip_n <= !(!mode_q[LVS_BIT_DIP_DIS] && (to_hit_q || dip_q));
        end
    end

    // ========================================
    // Status and interrupt
    logic clr;
    logic [15:0] set_v;
    logic [15:0] status_d;

    assign clr = reg_rd && (reg_addr == LVS_ADDR_STATUS_CLR);

    always_comb begin
        set_v = 16'h0000;
        set_v[LVS_ST_ZX] = zx_ev;
        set_v[LVS_ST_TIMEOUT] = to_ev;
        set_v[LVS_ST_DIP] = dip_ev;
        status_d = (clr ? 16'h0000 : status_q) | set_v;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            status_q <= 16'h0000;
            irq_n <= 1'b1;
        end else begin
            status_q <= status_d;
            irq_n <= ~|(status_d & irq_en_q);
        end
    end

    AST_ZX_FLAG: assert property (@(posedge clock) disable iff (!rstn)
        zx_ev |=> status_q[LVS_ST_ZX])
        else $error("zero cross flag not set");
    AST_CLR: assert property (@(posedge clock) disable iff (!rstn)
        clr && set_v == 16'h0000 |=> status_q == 16'h0000 && irq_n)
        else $error("status clear failed");
    AST_RELOAD: assert property (@(posedge clock) disable iff (!rstn)
        zx_ev |=> to_cnt_q == $past(zero_cross_timeout_q))
        else $error("timeout not reloaded");
    AST_TO_FLAG: assert property (@(posedge clock) disable iff (!rstn)
        to_ev |=> status_q[LVS_ST_TIMEOUT])
        else $error("timeout flag missing");
    AST_DIP_INACT: assert property (@(posedge clock) disable iff (!rstn)
        !active |=> !dip_n)
        else $error("dip not low while inactive");
    AST_PER_MSB: assert property (@(posedge clock) disable iff (!rstn)
        !line_period[15])
        else $error("period msb set");
    AST_DIP_FLAG: assert property (@(posedge clock) disable iff (!rstn)
        dip_ev |=> status_q[LVS_ST_DIP])
        else $error("dip flag missing");
    AST_DIV: assert property (@(posedge clock) disable iff (!rstn)
        tick |=> !tick [*8])
        else $error("tick spacing wrong");
endmodule

// file: verification/lvs_host_model.sv
// Host side model: watches the interrupt and dip pins like port inputs
`timescale 1ns/10ps
module lvs_host_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Pins watched
    input wire logic irq_n,
    input wire logic dip_n,
    // Falling edge counts
    output logic [7:0] irq_falls,
    output logic [7:0] dip_falls
);
    logic irq_n_q;
    logic dip_n_q;
    // Edge triggered, as a host pin would be; the cause is read elsewhere
    always_ff @(posedge clock) begin
        irq_n_q <= irq_n;
        dip_n_q <= dip_n;
        if (!rstn) begin
            irq_falls <= 8'h00;
            dip_falls <= 8'h00;
        end else begin
            if (irq_n_q && !irq_n) begin
                irq_falls <= irq_falls + 8'h01;
            end
            if (dip_n_q && !dip_n) begin
                dip_falls <= dip_falls + 8'h01;
            end
        end
    end
endmodule

// file: verification/testbench.sv
// Self-checking bench of the line voltage supervisor
`timescale 1ns/10ps
module testbench;
    import lvs_pkg::*;
    typedef struct {logic [5:0] addr; logic [15:0] exp;} lvs_row_t;
    logic clock;
    logic rstn;
    logic [5:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic sample_valid;
    logic [15:0] first_lowpass_filter;
    logic analog_supply_ok;
    logic zero_cross_out;
    logic irq_n;
    logic dip_n;
    logic integrator_en;
    logic active;
    logic [7:0] irq_falls;
    logic [7:0] dip_falls;
    logic [15:0] rd;
    logic [15:0] p1;
    logic [15:0] p2;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    lvs_row_t rows [7];

    lvs_supervisor lvs_supervisor_inst (.clock, .rstn, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .reg_rdata, .sample_valid,
        .first_lowpass_filter, .analog_supply_ok, .zero_cross_out, .irq_n,
        .dip_n, .integrator_en, .active);
    lvs_host_model lvs_host_model_inst (.clock, .rstn, .irq_n, .dip_n,
        .irq_falls, .dip_falls);

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ========================================
    // Shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic reg_write(input logic [5:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask
    task automatic reg_read(input logic [5:0] a, output logic [15:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        tick(1);
        d = reg_rdata;
    endtask
    task automatic send(input logic [15:0] v);
        first_lowpass_filter = v;
        sample_valid = 1'b1;
        tick(1);
        sample_valid = 1'b0;
        tick(7);
    endtask
    // One line cycle of 64 clocks, positive half first
    task automatic line_cycle(input logic [15:0] amp);
        repeat (4) send(amp);
        repeat (4) send(16'h0000 - amp);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            failures++;
            wrap_up();
        end
    end

    // ========================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        reg_addr = 6'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
        sample_valid = 1'b0;
        first_lowpass_filter = 16'h0000;
        analog_supply_ok = 1'b1;
        rows = '{'{LVS_ADDR_TIMEOUT, {4'h0, LVS_TIMEOUT_RST}},
            '{LVS_ADDR_DIP_CYC, {8'h00, LVS_DIP_CYC_RST}},
            '{LVS_ADDR_DIP_LVL, {8'h00, LVS_DIP_LVL_RST}},
            '{LVS_ADDR_IRQ_EN, LVS_IRQ_EN_RST},
            '{LVS_ADDR_MODE, LVS_MODE_RST},
            '{LVS_ADDR_STATUS, 16'h0000}, '{6'h3f, 16'h0000}};
        tick(10);
        cmp_bit(integrator_en, 1'b0);
        cmp_bit(irq_n, 1'b1);
        rstn = 1'b1;
        tick(1);
        cmp_bit(dip_n, 1'b0);
        for (int i = 0; i < 100 && active !== 1'b1; i++) tick(1);
        tick(1);
        cmp_bit(dip_n, 1'b1);
        foreach (rows[i]) begin
            reg_read(rows[i].addr, rd);
            cmp_word(rd, rows[i].exp);
        end
        reg_write(LVS_ADDR_OFFSET1, 16'h0080);
        cmp_bit(integrator_en, 1'b1);
        reg_write(LVS_ADDR_OFFSET1, 16'h001f);
        cmp_bit(integrator_en, 1'b0);
        reg_write(LVS_ADDR_TIMEOUT, 16'hfabc);
        reg_read(LVS_ADDR_TIMEOUT, rd);
        cmp_word(rd, 16'h0abc);
        // Zero crossing, flag, interrupt and its clearing read
        reg_write(LVS_ADDR_IRQ_EN, 16'h0001 << LVS_ST_ZX);
        send(16'hf000);
        cmp_bit(zero_cross_out, 1'b0);
        send(16'h1000);
        cmp_bit(zero_cross_out, 1'b1);
        cmp_bit(irq_n, 1'b0);
        cmp_word({8'h00, irq_falls}, 16'h0001);
        reg_read(LVS_ADDR_STATUS, rd);
        cmp_bit(rd[LVS_ST_ZX], 1'b1);
        reg_read(LVS_ADDR_STATUS_CLR, rd);
        tick(1);
        cmp_bit(irq_n, 1'b1);
        reg_read(LVS_ADDR_STATUS, rd);
        cmp_bit(rd[LVS_ST_ZX], 1'b0);
        // Timeout of two ticks with its interrupt masked
        reg_write(LVS_ADDR_IRQ_EN, 16'h0000);
        reg_write(LVS_ADDR_TIMEOUT, 16'h0002);
        send(16'hf000);
        tick(110);
        cmp_bit(dip_n, 1'b1);
        for (int i = 0; i < 200 && dip_n !== 1'b0; i++) tick(1);
        cmp_bit(dip_n, 1'b0);
        reg_write(LVS_ADDR_MODE, 16'h0001 << LVS_BIT_DIP_DIS);
        cmp_bit(dip_n, 1'b1);
        reg_read(LVS_ADDR_STATUS, rd);
        cmp_bit(rd[LVS_ST_TIMEOUT], 1'b1);
        cmp_bit(irq_n, 1'b1);
        reg_write(LVS_ADDR_IRQ_EN, 16'h0001 << LVS_ST_TIMEOUT);
        cmp_bit(irq_n, 1'b0);
        reg_write(LVS_ADDR_TIMEOUT, 16'h0fff);
        reg_write(LVS_ADDR_IRQ_EN, 16'h0001 << LVS_ST_DIP);
        reg_write(LVS_ADDR_MODE, 16'h0000);
        cmp_bit(dip_n, 1'b0);
        send(16'h4000);
        cmp_bit(dip_n, 1'b1);
        reg_read(LVS_ADDR_STATUS_CLR, rd);
        // Dip: three low cycles needed, a high cycle restarts the count
        reg_write(LVS_ADDR_DIP_LVL, 16'h0040);
        reg_write(LVS_ADDR_DIP_CYC, 16'h0004);
        repeat (2) line_cycle(16'h0100);
        line_cycle(16'h4000);
        repeat (2) line_cycle(16'h0100);
        cmp_bit(dip_n, 1'b1);
        repeat (3) line_cycle(16'h0100);
        cmp_bit(dip_n, 1'b0);
        cmp_word({8'h00, dip_falls}, 16'h0003);
        cmp_bit(irq_n, 1'b0);
        reg_read(LVS_ADDR_STATUS, rd);
        cmp_bit(rd[LVS_ST_DIP], 1'b1);
        line_cycle(16'h4000);
        cmp_bit(dip_n, 1'b1);
        // Period of 64 clocks once the filter has settled
        repeat (48) line_cycle(16'h4000);
        reg_read(LVS_ADDR_PERIOD, p1);
        repeat (8) line_cycle(16'h4000);
        reg_read(LVS_ADDR_PERIOD, p2);
        cmp_bit(p1[15], 1'b0);
        cmp_bit(p1 > 16'h0037 && p1 < 16'h0049, 1'b1);
        cmp_bit(p2 - p1 + 16'h0001 <= 16'h0002, 1'b1);
        // Supply loss: inactive, dip held low, samples ignored
        analog_supply_ok = 1'b0;
        for (int i = 0; i < 100 && active !== 1'b0; i++) tick(1);
        tick(1);
        cmp_bit(active, 1'b0);
        cmp_bit(dip_n, 1'b0);
        send(16'h4000);
        cmp_bit(zero_cross_out, 1'b0);
        cmp_word({8'h00, dip_falls}, 16'h0004);
        wrap_up();
    end
endmodule
